// ==== ptcs_pkg.sv ====
/*
 Constants and types for the per-port I/O pin timing clock selection block.
 Assumes a single pclk domain; clock pins arrive asynchronously and are sampled.
*/
`default_nettype none
package ptcs_pkg;
   // Register map
   localparam logic [11:0] ADDR_CTRL     = 12'h000;
   localparam logic [11:0] ADDR_STATUS   = 12'h004;
   localparam logic [11:0] ADDR_SOURCE   = 12'h008;
   // Control fields
   localparam int          CTRL_TX_LINE_TIMING_SELECT_BIT = 0;
   localparam int          CTRL_TX_FRAMER_TIMING_SELECT_BIT = 1;
   localparam int          CTRL_RX_FRAMER_TIMING_SELECT_BIT = 2;
   localparam int          CTRL_LOOP_BIT = 3;
   localparam int          CTRL_CLOCK_RATE_ADAPTER_BIT = 4;
   localparam int          CTRL_LB_LSB   = 5;
   localparam logic [7:0]  CTRL_RESET    = 8'h00;
   // Status fields: one valid-clock mask per pin group
   localparam int          STAT_TXL_LSB  = 0;
   localparam int          STAT_TXF_LSB  = 5;
   localparam int          STAT_RXF_LSB  = 10;
   localparam int          STAT_RXL_LSB  = 15;
   // Valid-clock mask bit positions
   localparam int          M_TLCLK       = 0;
   localparam int          M_TCLKO       = 1;
   localparam int          M_RCLKO       = 2;
   localparam int          M_RLCLK       = 3;
   localparam int          M_TCLKI       = 4;
   localparam logic [4:0]  MASK_NONE     = 5'h00;
   // Loopback codes
   localparam logic [2:0]  LB_NONE       = 3'h0;
   localparam logic [2:0]  LB_ANALOG     = 3'h1;
   localparam logic [2:0]  LB_LINE       = 3'h2;
   localparam logic [2:0]  LB_PAYLOAD    = 3'h3;
   localparam logic [2:0]  LB_DIAG       = 3'h4;
   localparam logic [2:0]  LB_DIAG_LINE  = 3'h6;
   // Clock sources, index into the sampled clock vector
   typedef enum logic [1:0] {SRC_RLCLK, SRC_TCLKI, SRC_ADAPT} ptcs_src_t;
   localparam int          NUM_SRC       = 3;
endpackage
`default_nettype wire

// ==== ptcs_clk_sense.sv ====
/*
 Samples one asynchronous clock pin into pclk and reports its level and rising edge.
 Assumes the sampled clock runs well below half the pclk rate.
*/
`default_nettype none
module ptcs_clk_sense (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Pin side
   input  wire logic clk_pin,
   // Sampled results
   output logic      lvl,
   output logic      rise
);
   logic meta_ff;
   logic sync_ff;
   logic last_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         last_ff <= 1'b0;
      end else begin
         meta_ff <= clk_pin;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
      end
   end

   assign lvl  = sync_ff;
   assign rise = sync_ff & ~last_ff;
endmodule
`default_nettype wire

// ==== ptcs_top.sv ====
/*
 Per-port I/O pin timing clock selection: output clock muxing, per-group I/O flop
 clock choice, valid-clock reporting and an APB register slave.
 Assumes clock pins are slow against pclk and arrive unsynchronised.
*/
// How it works
// - Transmit line pins: select 0 uses output clock, 1 uses input clock.
// - Transmit line pins timed like tx line clock out, valid at select 0.
// - Tx line input timing without line loops: tx clock in valid if adapter selected.
// - Tx line input timing with line, payload or combined loop uses rx line clock.
// - Tx line output timing valid clocks depend on loopback code.
// - Transmit framer pins: select 0 output clock, 1 input clock.
// - Transmit framer pins timed like internal tx clock out, valid at select 0.
// - Tx framer output timing valid clocks depend on loopback code.
// - Tx framer input timing: payload loop uses rx line clock, else adapter rule.
// - Loop timing: outputs clocks valid, or rx line clock for input timing.
// - Receive line pins always sampled on rx line clock input.
// - Receive framer pins: select 0 output clock, 1 input clock.
// - Receive framer pins timed like rx clock out, valid at select 0.
// - Rx framer output timing valid clocks depend on loopback code.
// - Rx framer input timing: diagnostic loops use adapter rule, else rx line clock.
// - Each timed input is synced in two pclk stages, then captured on the sampled rise of the selected clock.
// - Each timed output launched in pclk on the sampled rise of the selected clock pin.
`default_nettype none
module ptcs_top
   import ptcs_pkg::*;
(
   // APB slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Clock pins and adapter clock
   input  wire logic        rx_line_clock_in,
   input  wire logic        tx_clock_in,
   input  wire logic        clock_rate_adapter,
   output logic             tx_line_clock_out,
   output logic             internal_tx_clock_out,
   output logic             rx_clock_out,
   // Transmit line pins
   output logic             tx_line_positive_data,
   output logic             tx_line_negative_or_oh_mark,
   // Transmit framer pins
   input  wire logic        tx_overhead_or_serial_in,
   input  wire logic        tx_overhead_enable_in,
   input  wire logic        tx_overhead_mark_or_sof_in,
   output logic             tx_sof_or_data_enable_out,
   output logic             tx_payload_enable_out,
   // Receive line pins
   input  wire logic        rx_line_positive_data,
   input  wire logic        rx_line_negative_or_violation,
   // Receive framer pins
   input  wire logic        rx_overhead_enable_in,
   output logic             rx_serial_out,
   output logic             rx_sof_or_data_enable_out,
   // Core side
   input  wire logic        core_tx_pos,
   input  wire logic        core_tx_neg,
   input  wire logic        core_tx_sof,
   input  wire logic        core_tx_pden,
   input  wire logic        core_rx_ser,
   input  wire logic        core_rx_sof,
   output logic      [2:0]  core_tx_frm_in,
   output logic      [1:0]  core_rx_line_in,
   output logic             core_rx_ohen_in
);
   logic [7:0]         ctrl_ff;
   logic [31:0]        prdata_ff;
   logic               pready_ff, pslverr_ff;
   logic [NUM_SRC-1:0] src_pin, src_lvl, src_rise;
   logic               tx_line_timing_select, tx_framer_timing_select, rx_framer_timing_select, loop_timing_enable, clock_adapter_select;
   logic [2:0]         lbm;
   ptcs_src_t          tl_src, tco_src, rco_src;
   ptcs_src_t          txl_io, txf_io, rxf_io;
   logic [4:0]         txl_mask, txf_mask, rxf_mask, rxl_mask;
   logic               txl_edge, txf_edge, rxf_edge, rxl_edge;
   logic               tl_out_ff, tco_out_ff, rco_out_ff;
   logic [1:0]         txl_pin_ff, txf_out_ff, rxl_in_ff, rxf_out_ff;
   logic [2:0]         txf_in_ff;
   logic               rxf_in_ff;
   logic [5:0]         din_meta_ff, din_sync_ff;
   logic               apb_setup, apb_access;

   assign src_pin = {clock_rate_adapter, tx_clock_in, rx_line_clock_in};

   // Sampling of every clock source
   genvar gi;
   generate
      for (gi = 0; gi < NUM_SRC; gi++) begin : g_sense
         ptcs_clk_sense u_sense (
            .pclk    (pclk),
            .presetn (presetn),
            .clk_pin (src_pin[gi]),
            .lvl     (src_lvl[gi]),
            .rise    (src_rise[gi])
         );
      end
   endgenerate

   // Two-stage sync of the timed data pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         din_meta_ff <= 6'h00;
         din_sync_ff <= 6'h00;
      end else begin
         din_meta_ff <= {rx_overhead_enable_in, rx_line_negative_or_violation, rx_line_positive_data,
                         tx_overhead_mark_or_sof_in, tx_overhead_enable_in, tx_overhead_or_serial_in};
         din_sync_ff <= din_meta_ff;
      end
   end

   assign tx_line_timing_select  = ctrl_ff[CTRL_TX_LINE_TIMING_SELECT_BIT];
   assign tx_framer_timing_select  = ctrl_ff[CTRL_TX_FRAMER_TIMING_SELECT_BIT];
   assign rx_framer_timing_select  = ctrl_ff[CTRL_RX_FRAMER_TIMING_SELECT_BIT];
   assign loop_timing_enable = ctrl_ff[CTRL_LOOP_BIT];
   assign clock_adapter_select = ctrl_ff[CTRL_CLOCK_RATE_ADAPTER_BIT];
   assign lbm   = ctrl_ff[CTRL_LB_LSB +: 3];

   function automatic ptcs_src_t tx_base(input logic ad);
      tx_base = ad ? SRC_TCLKI : SRC_ADAPT;
   endfunction

   // Input timing picks the valid input pin, else the functional source
   function automatic ptcs_src_t io_pick(input logic ts, input logic [4:0] m, input ptcs_src_t fsrc);
      io_pick = !ts ? fsrc : m[M_RLCLK] ? SRC_RLCLK : m[M_TCLKI] ? SRC_TCLKI : fsrc;
   endfunction

   // Functional clock sources, independent of the timing selects
   always_comb begin
      tl_src  = tx_base(clock_adapter_select);
      tco_src = tx_base(clock_adapter_select);
      rco_src = SRC_RLCLK;
      if (loop_timing_enable || lbm == LB_LINE || lbm == LB_DIAG_LINE)
         tl_src = SRC_RLCLK;
      if (loop_timing_enable || lbm == LB_PAYLOAD)
         tco_src = SRC_RLCLK;
      if (!loop_timing_enable && lbm[2])
         rco_src = tx_base(clock_adapter_select);
      else if (!loop_timing_enable && lbm == LB_ANALOG && clock_adapter_select)
         rco_src = SRC_TCLKI;
   end

   // Valid clock masks, transmit line group
   always_comb begin
      txl_mask = MASK_NONE;
      if (loop_timing_enable)
         txl_mask = tx_line_timing_select ? 5'h08 : 5'h07;
      else if (!tx_line_timing_select)
         case (lbm)
            LB_DIAG:             txl_mask = 5'h07;
            LB_LINE, LB_PAYLOAD: txl_mask = 5'h05;
            LB_DIAG_LINE:        txl_mask = 5'h01;
            default:             txl_mask = 5'h03;
         endcase
      else if (lbm == LB_LINE || lbm == LB_PAYLOAD || lbm == LB_DIAG_LINE)
         txl_mask[M_RLCLK] = 1'b1;
      else
         txl_mask[M_TCLKI] = clock_adapter_select;
   end

   // Valid clock masks, transmit framer group
   always_comb begin
      txf_mask = MASK_NONE;
      if (loop_timing_enable)
         txf_mask = tx_framer_timing_select ? 5'h08 : 5'h07;
      else if (!tx_framer_timing_select)
         case (lbm)
            LB_PAYLOAD, LB_DIAG, LB_ANALOG: txf_mask = 5'h07;
            LB_DIAG_LINE:                   txf_mask = 5'h06;
            LB_NONE:                        txf_mask = 5'h03;
            default:                        txf_mask = 5'h02;
         endcase
      else if (lbm == LB_PAYLOAD)
         txf_mask[M_RLCLK] = 1'b1;
      else
         txf_mask[M_TCLKI] = clock_adapter_select;
   end

   // Valid clock masks, receive framer group
   always_comb begin
      rxf_mask = MASK_NONE;
      if (loop_timing_enable)
         rxf_mask = rx_framer_timing_select ? 5'h08 : 5'h07;
      else if (!rx_framer_timing_select)
         case (lbm)
            LB_PAYLOAD, LB_DIAG, LB_ANALOG: rxf_mask = 5'h07;
            LB_DIAG_LINE:                   rxf_mask = 5'h06;
            LB_LINE:                        rxf_mask = 5'h05;
            default:                        rxf_mask = 5'h04;
         endcase
      else if (lbm == LB_DIAG || lbm == LB_DIAG_LINE)
         rxf_mask[M_TCLKI] = clock_adapter_select;
      else
         rxf_mask[M_RLCLK] = 1'b1;
   end

   assign rxl_mask = 5'h08;

   // Per-group I/O flop clock mux
   assign txl_io   = io_pick(tx_line_timing_select, txl_mask, tl_src);
   assign txf_io   = io_pick(tx_framer_timing_select, txf_mask, tco_src);
   assign rxf_io   = io_pick(rx_framer_timing_select, rxf_mask, rco_src);
   assign txl_edge = src_rise[txl_io];
   assign txf_edge = src_rise[txf_io];
   assign rxf_edge = src_rise[rxf_io];
   assign rxl_edge = src_rise[SRC_RLCLK];

   // Output clock pins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         {tl_out_ff, tco_out_ff, rco_out_ff} <= 3'h0;
      else
         {tl_out_ff, tco_out_ff, rco_out_ff} <= {src_lvl[tl_src], src_lvl[tco_src], src_lvl[rco_src]};
   end

   // Launch of timed outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         {txl_pin_ff, txf_out_ff, rxf_out_ff} <= 6'h00;
      else begin
         if (txl_edge)
            txl_pin_ff <= {core_tx_neg, core_tx_pos};
         if (txf_edge)
            txf_out_ff <= {core_tx_pden, core_tx_sof};
         if (rxf_edge)
            rxf_out_ff <= {core_rx_sof, core_rx_ser};
      end
   end

   // Capture of timed inputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         {txf_in_ff, rxl_in_ff, rxf_in_ff} <= 6'h00;
      else begin
         if (txf_edge)
            txf_in_ff <= din_sync_ff[2:0];
         if (rxl_edge)
            rxl_in_ff <= din_sync_ff[4:3];
         if (rxf_edge)
            rxf_in_ff <= din_sync_ff[5];
      end
   end

   // APB slave, one wait-free access phase
   assign apb_setup  = psel & ~penable;
   assign apb_access = psel & penable & pready_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff  <= apb_setup;
         pslverr_ff <= apb_setup && paddr != ADDR_CTRL && paddr != ADDR_STATUS && paddr != ADDR_SOURCE;
         if (apb_setup && !pwrite) begin
            case (paddr)
               ADDR_CTRL:   prdata_ff <= {24'h00_0000, ctrl_ff};
               ADDR_STATUS: prdata_ff <= {12'h000, rxl_mask, rxf_mask, txf_mask, txl_mask};
               ADDR_SOURCE: prdata_ff <= {20'h0_0000, rxf_io, txf_io, txl_io, rco_src, tco_src, tl_src};
               default:     prdata_ff <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ctrl_ff <= CTRL_RESET;
      else if (apb_access && pwrite && paddr == ADDR_CTRL)
         ctrl_ff <= pwdata[7:0];
   end

   assign prdata                      = prdata_ff;
   assign pready                      = pready_ff;
   assign pslverr                     = pslverr_ff;
   assign tx_line_clock_out           = tl_out_ff;
   assign internal_tx_clock_out       = tco_out_ff;
   assign rx_clock_out                = rco_out_ff;
   assign tx_line_positive_data       = txl_pin_ff[0];
   assign tx_line_negative_or_oh_mark = txl_pin_ff[1];
   assign tx_sof_or_data_enable_out   = txf_out_ff[0];
   assign tx_payload_enable_out       = txf_out_ff[1];
   assign rx_serial_out               = rxf_out_ff[0];
   assign rx_sof_or_data_enable_out   = rxf_out_ff[1];
   assign core_tx_frm_in              = txf_in_ff;
   assign core_rx_line_in             = rxl_in_ff;
   assign core_rx_ohen_in             = rxf_in_ff;

   // Checks
   a_txl_out_timing: assert property (@(posedge pclk) disable iff (!presetn)
      (!tx_line_timing_select && src_rise[tl_src]) |=> tx_line_positive_data == $past(core_tx_pos))
      else $error("tx line data not launched on tx line clock");
   a_rxl_capture: assert property (@(posedge pclk) disable iff (!presetn)
      src_rise[SRC_RLCLK] |=> core_rx_line_in[0] == $past(din_sync_ff[3]))
      else $error("rx line data not captured on rx line clock");
   a_loop_rlclk: assert property (@(posedge pclk) disable iff (!presetn)
      loop_timing_enable |-> (tl_src == SRC_RLCLK && tco_src == SRC_RLCLK && rco_src == SRC_RLCLK))
      else $error("loop timing does not use rx line clock");
   a_txl_in_adapter: assert property (@(posedge pclk) disable iff (!presetn)
      (tx_line_timing_select && !loop_timing_enable && lbm == LB_NONE) |-> txl_mask[M_TCLKI] == clock_adapter_select && !txl_mask[M_RLCLK])
      else $error("tx line input timing valid clock wrong");
   a_txl_in_loop: assert property (@(posedge pclk) disable iff (!presetn)
      (tx_line_timing_select && (lbm == LB_LINE || lbm == LB_PAYLOAD)) |-> txl_io == SRC_RLCLK)
      else $error("tx line input timing not on rx line clock");
   a_txf_out_follow: assert property (@(posedge pclk) disable iff (!presetn)
      (!tx_framer_timing_select && $stable(tco_src)) |=> internal_tx_clock_out == $past(src_lvl[tco_src]))
      else $error("internal tx clock out not from its source");
   a_txf_in_payload: assert property (@(posedge pclk) disable iff (!presetn)
      (tx_framer_timing_select && !loop_timing_enable && lbm == LB_PAYLOAD) |-> txf_io == SRC_RLCLK)
      else $error("tx framer input timing not on rx line clock");
   a_rxf_in_diag: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_framer_timing_select && !loop_timing_enable && lbm == LB_DIAG && clock_adapter_select) |-> rxf_io == SRC_TCLKI)
      else $error("rx framer input timing not on tx clock in");
   a_rxf_launch: assert property (@(posedge pclk) disable iff (!presetn)
      rxf_edge |=> rx_serial_out == $past(core_rx_ser))
      else $error("rx serial not launched on selected clock");
   a_sel_no_func: assert property (@(posedge pclk) disable iff (!presetn)
      ($changed(tx_line_timing_select) && $stable(lbm) && $stable(loop_timing_enable) && $stable(clock_adapter_select)) |-> $stable(tl_src))
      else $error("timing select changed a functional clock");
   a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready ##1 !pready)
      else $error("apb ready not a single cycle after setup");
endmodule
`default_nettype wire

// ==== ptcs_far_end.sv ====
/* Far-end model: line interface and framer logic at the pins.
 Assumes all groups use output clock timing and the clocks run only while run is high. */
`default_nettype none
module ptcs_far_end (
   // Bench control
   input  wire logic       run,
   input  wire logic [2:0] rx_val,
   input  wire logic [2:0] tx_val,
   // Clock pins
   input  wire logic       internal_tx_clock_out,
   input  wire logic       rx_clock_out,
   output logic            rx_line_clock_in,
   output logic            tx_clock_in,
   output logic            clock_rate_adapter,
   // Data pins
   output logic            rx_line_positive_data,
   output logic            rx_line_negative_or_violation,
   output logic            rx_overhead_enable_in,
   output logic            tx_overhead_or_serial_in,
   output logic            tx_overhead_enable_in,
   output logic            tx_overhead_mark_or_sof_in
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      {rx_line_clock_in, tx_clock_in, clock_rate_adapter} = 3'h0;
      {rx_line_negative_or_violation, rx_line_positive_data, rx_overhead_enable_in} = 3'h0;
      {tx_overhead_mark_or_sof_in, tx_overhead_enable_in, tx_overhead_or_serial_in} = 3'h0;
   end
   // Three unrelated 125 ns clocks
   always begin
      #62.5;
      if (run) rx_line_clock_in = ~rx_line_clock_in;
   end
   always begin
      #21.3;
      if (run) tx_clock_in = ~tx_clock_in;
      #41.2;
   end
   always begin
      #37.1;
      if (run) clock_rate_adapter = ~clock_rate_adapter;
      #25.4;
   end
   // Line data launched against the rx line clock
   always @(negedge rx_line_clock_in)
      {rx_line_negative_or_violation, rx_line_positive_data} <= rx_val[1:0];
   // Framer inputs launched against the selected output clocks
   always @(negedge rx_clock_out)
      rx_overhead_enable_in <= rx_val[2];
   always @(negedge internal_tx_clock_out)
      {tx_overhead_mark_or_sof_in, tx_overhead_enable_in, tx_overhead_or_serial_in} <= tx_val;
endmodule
`default_nettype wire

// ==== testbench.sv ====
/* Self-checking bench for the pin timing clock select block.
 Assumes the APB map and status layout of the package; far end in ptcs_far_end. */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import ptcs_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0;
   logic [2:0] rx_val = 0, tx_val = 0;
   logic core_tx_pos = 0, core_tx_neg = 0, core_tx_sof = 0, core_tx_pden = 0, core_rx_ser = 0, core_rx_sof = 0;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, rx_line_clock_in, tx_clock_in, clock_rate_adapter, tx_line_clock_out;
   wire logic internal_tx_clock_out, rx_clock_out, tx_line_positive_data, tx_line_negative_or_oh_mark;
   wire logic tx_overhead_or_serial_in, tx_overhead_enable_in, tx_overhead_mark_or_sof_in;
   wire logic tx_sof_or_data_enable_out, tx_payload_enable_out, rx_line_positive_data;
   wire logic rx_line_negative_or_violation, rx_overhead_enable_in, rx_serial_out, rx_sof_or_data_enable_out;
   wire logic [2:0] core_tx_frm_in;
   wire logic [1:0] core_rx_line_in;
   wire logic core_rx_ohen_in;
   wire logic [11:0] pins;
   int err_count = 0, checked = 0;
   assign pins = {tx_line_positive_data, tx_line_negative_or_oh_mark, tx_sof_or_data_enable_out,
                  tx_payload_enable_out, rx_serial_out, rx_sof_or_data_enable_out, core_tx_frm_in,
                  core_rx_line_in, core_rx_ohen_in};
   always #4 pclk = ~pclk;
   ptcs_top i_ptcs_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .rx_line_clock_in, .tx_clock_in, .clock_rate_adapter, .tx_line_clock_out,
      .internal_tx_clock_out, .rx_clock_out, .tx_line_positive_data, .tx_line_negative_or_oh_mark,
      .tx_overhead_or_serial_in, .tx_overhead_enable_in, .tx_overhead_mark_or_sof_in,
      .tx_sof_or_data_enable_out, .tx_payload_enable_out, .rx_line_positive_data,
      .rx_line_negative_or_violation, .rx_overhead_enable_in, .rx_serial_out, .rx_sof_or_data_enable_out,
      .core_tx_pos, .core_tx_neg, .core_tx_sof, .core_tx_pden, .core_rx_ser, .core_rx_sof,
      .core_tx_frm_in, .core_rx_line_in, .core_rx_ohen_in);
   ptcs_far_end i_ptcs_far_end (.run, .rx_val, .tx_val, .internal_tx_clock_out, .rx_clock_out,
      .rx_line_clock_in, .tx_clock_in, .clock_rate_adapter, .rx_line_positive_data,
      .rx_line_negative_or_violation, .rx_overhead_enable_in, .tx_overhead_or_serial_in,
      .tx_overhead_enable_in, .tx_overhead_mark_or_sof_in);

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      chk(n, 32'h1, "bus answer delay");
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Valid-clock masks: bit0 tx line, 1 internal tx, 2 rx out, 3 rx line in, 4 tx in
   function automatic logic [19:0] exp_stat(input logic [7:0] c);
      logic [4:0] txl, txf, rxf;
      logic [2:0] lb;
      lb = c[7:5];
      if (c[3]) begin
         txl = c[0] ? 5'h08 : 5'h07;
         txf = c[1] ? 5'h08 : 5'h07;
         rxf = c[2] ? 5'h08 : 5'h07;
      end else begin
         if (c[0]) txl = (lb == 3'h2 || lb == 3'h3 || lb == 3'h6) ? 5'h08 : (c[4] ? 5'h10 : 5'h00);
         else txl = (lb == 3'h4) ? 5'h07 : (lb == 3'h2 || lb == 3'h3) ? 5'h05 : (lb == 3'h6) ? 5'h01 : 5'h03;
         if (c[1]) txf = (lb == 3'h3) ? 5'h08 : (c[4] ? 5'h10 : 5'h00);
         else case (lb)
            3'h1, 3'h3, 3'h4: txf = 5'h07;
            3'h6: txf = 5'h06;
            3'h2, 3'h5, 3'h7: txf = 5'h02;
            default: txf = 5'h03;
         endcase
         if (c[2]) rxf = (lb == 3'h4 || lb == 3'h6) ? (c[4] ? 5'h10 : 5'h00) : 5'h08;
         else case (lb)
            3'h1, 3'h3, 3'h4: rxf = 5'h07;
            3'h6: rxf = 5'h06;
            3'h2: rxf = 5'h05;
            default: rxf = 5'h04;
         endcase
      end
      return {5'h08, rxf, txf, txl};
   endfunction

   task automatic check_status(input logic [7:0] c);
      logic [31:0] q;
      logic e;
      logic [19:0] x;
      x = exp_stat(c);
      apb(1'b0, ADDR_STATUS, 32'h0, q, e);
      chk({27'h0, q[4:0]}, {27'h0, x[4:0]}, "tx line mask");
      chk({27'h0, q[9:5]}, {27'h0, x[9:5]}, "tx framer mask");
      chk({27'h0, q[14:10]}, {27'h0, x[14:10]}, "rx framer mask");
      chk({15'h0, q[31:15]}, {27'h0, x[19:15]}, "rx line mask");
   endtask

   task automatic reset_values();
      logic [31:0] q;
      logic e;
      apb(1'b0, ADDR_CTRL, 32'h0, q, e);
      chk(q, {24'h0, CTRL_RESET}, "ctrl after reset");
      chk({31'h0, e}, 32'h0, "error on mapped read");
      apb(1'b0, ADDR_SOURCE, 32'h0, q, e);
      chk(q, 32'h0000_028a, "sources after reset");
      check_status(CTRL_RESET);
   endtask

   task automatic pin_timing();
      logic [31:0] q;
      logic e;
      int n;
      logic t0;
      apb(1'b1, ADDR_CTRL, 32'h0, q, e);
      {core_tx_pos, core_tx_neg, core_tx_sof, core_tx_pden, core_rx_ser, core_rx_sof} <= 6'h3f;
      rx_val <= 3'h7;
      tx_val <= 3'h7;
      repeat (40) @(posedge pclk);
      chk({20'h0, pins}, 32'h0, "pins moved with clocks stopped");
      run <= 1'b1;
      n = 0;
      while (pins !== 12'hfff && n < 400) begin
         @(posedge pclk);
         n++;
      end
      chk({20'h0, pins}, 32'hfff, "pins after clock edges");
      t0 = tx_line_clock_out;
      n = 0;
      while (tx_line_clock_out === t0 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      chk({31'h0, tx_line_clock_out !== t0}, 32'h1, "tx line clock out stuck");
   endtask

   task automatic sweep_modes();
      logic [31:0] q;
      logic e;
      for (int i = 0; i < 256; i++) begin
         apb(1'b1, ADDR_CTRL, {24'hffffff, i[7:0]}, q, e);
         apb(1'b0, ADDR_CTRL, 32'h0, q, e);
         chk(q, {24'h0, i[7:0]}, "ctrl readback");
         check_status(i[7:0]);
      end
   endtask

   task automatic bad_access();
      logic [31:0] q;
      logic e;
      apb(1'b1, 12'h00c, 32'h0, q, e);
      chk({31'h0, e}, 32'h1, "unmapped write not refused");
      apb(1'b0, 12'h00c, 32'h0, q, e);
      chk({q[31:1], e}, 32'h1, "unmapped read");
      apb(1'b1, ADDR_STATUS, 32'h0, q, e);
      apb(1'b0, ADDR_CTRL, 32'h0, q, e);
      chk(q, 32'hff, "ctrl disturbed");
      check_status(8'hff);
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      reset_values();
      pin_timing();
      sweep_modes();
      bad_access();
      give_verdict();
   end

   initial begin
      #300us;
      err_count++;
      give_verdict();
   end
endmodule
`default_nettype wire
